// File: hw/lafc_ack_timer.sv
module lafc_ack_timer (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // control
  input wire logic i_restart,
  input wire logic i_run,
  input wire logic i_long,
  // expiry
  output logic o_expire
);
  import lafc_pkg::*;

  localparam logic [TMR_W-1:0] LIM_SHORT = TMR_W'(ACK_TMO_SHORT_CYC - 1);
  localparam logic [TMR_W-1:0] LIM_LONG = TMR_W'(ACK_TMO_LONG_CYC - 1);

  logic [TMR_W-1:0] cnt_r;
  logic armed_r;
  logic [TMR_W-1:0] lim;

  // minimum count guarantees the low bound, well short of the high one
  assign lim = i_long ? LIM_LONG : LIM_SHORT;

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_r <= '0;
      armed_r <= 1'b0;
      o_expire <= 1'b0;
    end else begin
      o_expire <= 1'b0;
      if (i_restart) begin
        cnt_r <= '0;
        armed_r <= 1'b1;
      end else if (!i_run) begin
        armed_r <= 1'b0;
      end else if (armed_r) begin
        if (cnt_r >= lim) begin
          o_expire <= 1'b1;
          armed_r <= 1'b0;
        end else begin
          cnt_r <= cnt_r + 1'b1;
        end
      end
    end
  end

endmodule

// File: hw/lafc_port.sv
module lafc_port #(
  parameter bit CAPABLE = 1'b1,
  parameter int unsigned W_OUT = 8,
  parameter int unsigned W_OWE = 8
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // port control
  input lafc_pkg::lafc_pstate_t i_port_state,
  input wire logic i_ld_enable,
  input wire logic i_reduced_ack_timeout_bit_set,
  // receive characters
  input lafc_pkg::lafc_rx_t i_rx,
  output lafc_pkg::lafc_rx_t o_fwd,
  output logic [lafc_pkg::CHAN_W-1:0] o_chan,
  output logic o_chan_valid,
  output logic o_rr_pair,
  output logic o_release,
  // transmit characters
  input lafc_pkg::lafc_tx_t i_tx,
  output logic o_tx_ready,
  input wire logic i_rr_req,
  output logic o_rr_sent,
  output lafc_pkg::lafc_txo_t o_tx,
  // status
  output lafc_pkg::lafc_evt_t o_evt,
  output logic o_resend_all,
  output logic o_long_tmo,
  output logic [lafc_pkg::CNT_W-1:0] o_outstanding,
  output logic [lafc_pkg::CNT_W-1:0] o_owed
);
  import lafc_pkg::*;

  // elaboration checks
  if (W_OUT < 1 || W_OUT > CNT_W || W_OWE < 1 || W_OWE > CNT_W) begin : g_bad_w
    $error("lafc_port: counter widths must be 1 to 8");
  end
  if (!CAPABLE && (W_OUT != 1 || W_OWE != 1)) begin : g_bad_cap
    $error("lafc_port: ports without long distance use 1-bit counters");
  end

  localparam logic [CNT_W-1:0] OUT_MAX = CNT_W'((1 << W_OUT) - 1);
  localparam logic [CNT_W-1:0] OWE_MAX = CNT_W'((1 << W_OWE) - 1);

  typedef enum logic [1:0] {
    TX_PASS, TX_ACK2, TX_RR2, TX_ABFLAG
  } lafc_txst_t;

  // saturating up/down counter step
  function automatic logic [CNT_W-1:0] cnt_step(
    input logic [CNT_W-1:0] c,
    input logic up,
    input logic dn,
    input logic [CNT_W-1:0] max
  );
    cnt_step = c;
    if (up && !dn && c != max) begin
      cnt_step = c + 1'b1;
    end else if (dn && !up && c != CNT_RST) begin
      cnt_step = c - 1'b1;
    end
  endfunction

  // ---------------- receive side ----------------
  logic rx_v;
  logic rx_ack;
  logic rx_rr;
  logic ack_half_r;
  logic rr_half_r;
  logic ack_pair;
  logic ack_lone;
  logic rr_pair;
  logic rx_close;
  logic owe_inc;

  logic [CNT_W-1:0] out_r;
  logic [CNT_W-1:0] owe_r;
  logic out_inc;
  logic out_dec;
  logic owe_dec;
  logic proto_err;

  assign rx_v = i_rx.valid;
  assign rx_ack = rx_v && i_rx.kind == CH_ACK;
  assign rx_rr = rx_v && i_rx.kind == CH_RR;
  assign ack_pair = rx_ack && ack_half_r;
  assign ack_lone = ack_half_r && rx_v && !rx_ack;
  assign rr_pair = rx_rr && rr_half_r;
  assign rx_close = rx_v && i_rx.kind == CH_FLAG && i_rx.close;

  // pair assembly; a third identical character opens a new pair
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      ack_half_r <= 1'b0;
      rr_half_r <= 1'b0;
    end else if (rx_v) begin
      ack_half_r <= rx_ack && !ack_half_r;
      rr_half_r <= rx_rr && !rr_half_r;
    end
  end

  assign out_dec = ack_pair && out_r != CNT_RST;
  assign proto_err = (ack_pair && out_r == CNT_RST) || ack_lone;

  assign owe_inc = rx_close && i_rx.ok &&
                   ((i_port_state == PS_READY && is_acked(i_rx.ftype)) ||
                    (i_port_state == PS_CHECK &&
                     i_rx.ftype == FT_LINK_RESET));

  // forward path never carries ack or rr characters
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_fwd <= '0;
    end else begin
      o_fwd <= i_rx;
      o_fwd.valid <= rx_v && !rx_ack && !rx_rr;
    end
  end

  // channel component parse
  logic chan_half_r;
  logic [CHAN_LO_W-1:0] chan_hi_r;
  logic chan_rej;

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      chan_half_r <= 1'b0;
      chan_hi_r <= '0;
      o_chan <= '0;
      o_chan_valid <= 1'b0;
      chan_rej <= 1'b0;
    end else begin
      o_chan_valid <= 1'b0;
      chan_rej <= 1'b0;
      if (rx_v && i_rx.kind == CH_DATA && i_rx.chan) begin
        if (!chan_half_r) begin
          if (i_rx.data == CHAN_BAD_FIRST) begin
            chan_rej <= 1'b1;
          end else if (i_rx.data[CHAN_EXT_BIT]) begin
            chan_half_r <= 1'b1;
            chan_hi_r <= i_rx.data[CHAN_LO_W-1:0];
          end else begin
            o_chan <= CHAN_W'(i_rx.data[CHAN_LO_W-1:0]);
            o_chan_valid <= 1'b1;
          end
        end else begin
          chan_half_r <= 1'b0;
          if (i_rx.data[CHAN_EXT_BIT]) begin
            chan_rej <= 1'b1;
          end else begin
            o_chan <= {chan_hi_r, i_rx.data[CHAN_LO_W-1:0]};
            o_chan_valid <= 1'b1;
          end
        end
      end else if (rx_v && i_rx.kind == CH_FLAG && chan_half_r) begin
        chan_half_r <= 1'b0;
        chan_rej <= 1'b1;
      end
    end
  end

  // ---------------- mode and timer ----------------
  logic reduced_ack_timeout_bit_r;
  logic ld_active;
  logic long_sel;
  logic tmo_expire;
  logic tmr_restart;

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      reduced_ack_timeout_bit_r <= 1'b0;
    end else if (i_reduced_ack_timeout_bit_set) begin
      reduced_ack_timeout_bit_r <= 1'b1;
    end
  end

  assign ld_active = CAPABLE && i_ld_enable;
  assign long_sel = CAPABLE && !reduced_ack_timeout_bit_r;
  assign tmr_restart = out_inc || (CAPABLE && out_dec);

  lafc_ack_timer u_timer (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_restart(tmr_restart),
    .i_run(out_r != CNT_RST && i_port_state != PS_DISABLED),
    .i_long(long_sel),
    .o_expire(tmo_expire)
  );

  // ---------------- transmit side ----------------
  lafc_txst_t st_r;
  lafc_txst_t st_nxt;
  lafc_txo_t tx_nxt;
  logic rr_pend_r;
  logic gap_ack_r;
  logic gap_rr_r;
  logic abort_pend_r;
  logic closing;
  logic hold;
  logic consume;
  logic ack2_sent;
  logic rr2_sent;
  logic abort_now;

  assign closing = i_tx.valid && i_tx.kind == CH_FLAG && i_tx.close;
  assign hold = !ld_active && out_r != CNT_RST;

  always_comb begin
    st_nxt = st_r;
    tx_nxt.kind = CH_FILL;
    tx_nxt.data = 8'h00;
    consume = 1'b0;
    out_inc = 1'b0;
    ack2_sent = 1'b0;
    rr2_sent = 1'b0;
    abort_now = 1'b0;
    case (st_r)
      TX_PASS: begin
        if (closing && hold && (tmo_expire || abort_pend_r)) begin
          tx_nxt.kind = CH_ABORT;
          abort_now = 1'b1;
          st_nxt = TX_ABFLAG;
        end else if (owe_r != CNT_RST && !gap_ack_r) begin
          tx_nxt.kind = CH_ACK;
          st_nxt = TX_ACK2;
        end else if (rr_pend_r && !gap_rr_r) begin
          tx_nxt.kind = CH_RR;
          st_nxt = TX_RR2;
        end else if (closing && hold) begin
          tx_nxt.kind = CH_FILL;
        end else if (i_tx.valid) begin
          tx_nxt.kind = i_tx.kind;
          tx_nxt.data = i_tx.data;
          consume = 1'b1;
          out_inc = closing && is_acked(i_tx.ftype);
        end
      end
      TX_ACK2: begin
        tx_nxt.kind = CH_ACK;
        ack2_sent = 1'b1;
        st_nxt = TX_PASS;
      end
      TX_RR2: begin
        tx_nxt.kind = CH_RR;
        rr2_sent = 1'b1;
        st_nxt = TX_PASS;
      end
      TX_ABFLAG: begin
        tx_nxt.kind = CH_FLAG;
        consume = 1'b1;
        st_nxt = TX_PASS;
      end
      default: begin
        st_nxt = TX_PASS;
      end
    endcase
  end

  assign o_tx_ready = consume;
  assign owe_dec = ack2_sent;

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      st_r <= TX_PASS;
      o_tx <= '{kind: CH_FILL, data: 8'h00};
      gap_ack_r <= 1'b0;
      gap_rr_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      o_tx <= tx_nxt;
      gap_ack_r <= ack2_sent;
      gap_rr_r <= rr2_sent;
    end
  end

  // rr request held until its pair goes out; new request wins
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      rr_pend_r <= 1'b0;
    end else if (i_rr_req) begin
      rr_pend_r <= 1'b1;
    end else if (rr2_sent) begin
      rr_pend_r <= 1'b0;
    end
  end

  // timeout seen while a frame is not yet closing still aborts it
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      abort_pend_r <= 1'b0;
    end else if (tmo_expire && hold && !abort_now) begin
      abort_pend_r <= 1'b1;
    end else if (abort_now || !hold ||
                 i_port_state == PS_DISABLED) begin
      abort_pend_r <= 1'b0;
    end
  end

  // ---------------- ack counters ----------------
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      out_r <= CNT_RST;
    end else if (i_port_state == PS_DISABLED) begin
      out_r <= CNT_RST;
    end else begin
      out_r <= cnt_step(out_r, out_inc, out_dec, OUT_MAX);
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      owe_r <= CNT_RST;
    end else if (i_port_state == PS_DISABLED) begin
      owe_r <= CNT_RST;
    end else begin
      owe_r <= cnt_step(owe_r, owe_inc, owe_dec, OWE_MAX);
    end
  end

  // ---------------- events and status ----------------
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_evt <= '0;
      o_release <= 1'b0;
      o_rr_pair <= 1'b0;
      o_rr_sent <= 1'b0;
      o_resend_all <= 1'b0;
      o_long_tmo <= 1'b0;
    end else begin
      o_evt.frame_reject <= chan_rej;
      o_evt.proto_err <= proto_err;
      o_evt.ack_timeout <= tmo_expire;
      o_evt.abort <= abort_now;
      o_evt.erp_start <= chan_rej || proto_err || tmo_expire;
      o_release <= out_dec;
      o_rr_pair <= rr_pair;
      o_rr_sent <= rr2_sent;
      o_resend_all <= ld_active && out_r != CNT_RST;
      o_long_tmo <= long_sel;
    end
  end

  assign o_outstanding = out_r;
  assign o_owed = owe_r;

endmodule

// File: inc/lafc_pkg.sv
// How it works
// - channels 0-127 use one byte, 128-16383 use two bytes
// - first channel byte 80h or bad channel field raises frame reject
// - ack or rr acts only as two back-to-back identical characters
// - flow control per link; ack and rr never forwarded onward
// - due ack or rr pair may interleave inside a frame, with priority
// - ack every good received frame except the three reset/reserved types
// - received ack pair releases the matching transmitted frame
// - long-distance active: recovery resends every unacknowledged frame
// - ack counters single bits, or up to 8 bits when capable
// - entering disabled clears outstanding and owed ack counts
// - count up after closing flag of acked frames, down per ack pair
// - no ack within 25-50 us: set ack status, start recovery
// - capable ports use 100-200 us, restarted per ack pair, from reset
// - reduced-timeout bit shortens capable port timeout to 25-50 us
// - non long-distance with one outstanding withholds closing flag, sends filler
// - timeout while withholding aborts frame, sets status, starts recovery
// - long-distance enabled may close frames with acks outstanding
// - ack pair with none outstanding or lone ack: protocol error, recovery
// - owed count up on good frame: ready acked type incl. link reset, or check link reset
// - send ack pair while owed nonzero, never back to back, then count down
package lafc_pkg;

  localparam int unsigned CLK_MHZ = 40;
  localparam int unsigned ACK_TMO_SHORT_US = 25;
  localparam int unsigned ACK_TMO_LONG_US = 100;
  localparam int unsigned ACK_TMO_SHORT_CYC = ACK_TMO_SHORT_US * CLK_MHZ;
  localparam int unsigned ACK_TMO_LONG_CYC = ACK_TMO_LONG_US * CLK_MHZ;
  localparam int unsigned TMR_W = 13;

  localparam logic [7:0] CHAN_BAD_FIRST = 8'h80;
  localparam int unsigned CHAN_EXT_BIT = 7;
  localparam int unsigned CHAN_LO_W = 7;
  localparam int unsigned CHAN_W = 14;
  localparam int unsigned CNT_W = 8;
  localparam logic [7:0] CNT_RST = 8'h00;

  typedef enum logic [2:0] {
    CH_DATA, CH_FLAG, CH_ACK, CH_RR, CH_FILL, CH_ABORT, CH_OTHER
  } lafc_chr_t;

  typedef enum logic [2:0] {
    FT_NORMAL, FT_LINK_RESET, FT_TOTAL_RESET, FT_RESERVED, FT_ABS_RESET
  } lafc_ftype_t;

  typedef enum logic [1:0] {
    PS_DISABLED, PS_CHECK, PS_READY, PS_ENABLED
  } lafc_pstate_t;

  typedef struct packed {
    logic valid;
    lafc_chr_t kind;
    logic [7:0] data;
    logic chan;
    logic close;
    logic ok;
    lafc_ftype_t ftype;
  } lafc_rx_t;

  typedef struct packed {
    logic valid;
    lafc_chr_t kind;
    logic [7:0] data;
    logic close;
    lafc_ftype_t ftype;
  } lafc_tx_t;

  typedef struct packed {
    lafc_chr_t kind;
    logic [7:0] data;
  } lafc_txo_t;

  typedef struct packed {
    logic frame_reject;
    logic proto_err;
    logic ack_timeout;
    logic abort;
    logic erp_start;
  } lafc_evt_t;

  function automatic logic is_acked(input lafc_ftype_t ft);
    is_acked = !(ft == FT_TOTAL_RESET || ft == FT_RESERVED ||
                 ft == FT_ABS_RESET);
  endfunction

endpackage

// File: tb/lafc_peer.sv
module lafc_peer
  import lafc_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_auto,
  input wire logic [7:0] i_delay,
  input lafc_pkg::lafc_txo_t i_tx,
  output lafc_pkg::lafc_rx_t o_rx
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam lafc_rx_t ACK_C = '{1'b1, CH_ACK, 8'h00, 1'b0, 1'b0, 1'b1,
                                 FT_NORMAL};
  lafc_rx_t q[$];
  int pend = 0;
  int cnt = 0;
  lafc_chr_t last = CH_FILL;
  initial o_rx = '0;
  task automatic push(input lafc_rx_t c);
    q.push_back(c);
  endtask
  always @(negedge i_core_clk) begin
    // aborted frames are never acknowledged
    if (i_auto && i_tx.kind == CH_FLAG && last != CH_ABORT)
      pend++;
    last = i_tx.kind;
    if (pend == 0)
      cnt = 0;
    else if (cnt++ >= i_delay) begin
      // always a whole pair, per link only
      q.push_back(ACK_C);
      q.push_back(ACK_C);
      pend--;
      cnt = 0;
    end
    if (q.size() > 0)
      o_rx <= q.pop_front();
    else begin
      // idle line shows a changing pattern
      o_rx.valid <= 1'b0;
      o_rx.data <= ~o_rx.data;
    end
  end
endmodule

// File: tb/lafc_port_monitor.sv
module lafc_port_monitor
  import lafc_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst,
  input lafc_pkg::lafc_pstate_t i_port_state,
  input lafc_pkg::lafc_rx_t i_rx,
  input lafc_pkg::lafc_tx_t i_tx,
  input wire logic o_tx_ready,
  input lafc_pkg::lafc_rx_t o_fwd,
  input wire logic [lafc_pkg::CHAN_W-1:0] o_chan,
  input wire logic o_chan_valid,
  input wire logic o_release,
  input lafc_pkg::lafc_txo_t o_tx,
  input lafc_pkg::lafc_evt_t o_evt,
  input wire logic o_resend_all,
  input wire logic [lafc_pkg::CNT_W-1:0] o_outstanding,
  input wire logic [lafc_pkg::CNT_W-1:0] o_owed
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  sequence s_ack_pair;
    o_tx.kind == CH_ACK ##1 o_tx.kind == CH_ACK;
  endsequence
  property p_no_fwd;
    i_rx.valid && i_rx.kind inside {CH_ACK, CH_RR} |=> !o_fwd.valid;
  endproperty
  a_no_fwd: assert property (p_no_fwd)
    else $error("ack or rr forwarded");
  property p_chan;
    i_rx.valid && i_rx.kind == CH_DATA && i_rx.chan && !i_rx.data[7]
      |=> o_chan_valid && o_chan[6:0] == $past(i_rx.data[6:0]);
  endproperty
  a_chan: assert property (p_chan)
    else $error("channel byte not decoded");
  property p_reject;
    i_rx.valid && i_rx.chan && i_rx.data == CHAN_BAD_FIRST
      |-> ##2 o_evt.frame_reject && o_evt.erp_start;
  endproperty
  a_reject: assert property (p_reject)
    else $error("bad channel byte not rejected");
  property p_release;
    o_release |-> $past(o_outstanding) != 8'h00;
  endproperty
  a_release: assert property (p_release)
    else $error("release with nothing outstanding");
  property p_clear;
    i_port_state == PS_DISABLED && $past(i_port_state) != PS_DISABLED
      |=> o_outstanding == 8'h00 && o_owed == 8'h00;
  endproperty
  a_clear: assert property (p_clear)
    else $error("counters not cleared on disable");
  property p_out_inc;
    i_tx.valid && o_tx_ready && i_tx.kind == CH_FLAG && i_tx.close &&
      i_tx.ftype inside {FT_NORMAL, FT_LINK_RESET} &&
      i_port_state != PS_DISABLED
      |=> o_tx.kind == CH_FLAG && o_outstanding != 8'h00;
  endproperty
  a_out_inc: assert property (p_out_inc)
    else $error("outstanding not counted");
  property p_err_erp;
    o_evt.proto_err || o_evt.ack_timeout |-> o_evt.erp_start;
  endproperty
  a_err_erp: assert property (p_err_erp)
    else $error("error without recovery start");
  property p_pair_gap;
    s_ack_pair |=> o_tx.kind != CH_ACK;
  endproperty
  a_pair_gap: assert property (p_pair_gap)
    else $error("ack pairs back to back");
  property p_owed_dec;
    s_ack_pair |-> o_owed == $past(o_owed) - 8'h01 ||
      $past(i_rx.valid && i_rx.close);
  endproperty
  a_owed_dec: assert property (p_owed_dec)
    else $error("owed count not decremented");
  property p_owed_send;
    o_owed != 8'h00 |-> ##[0:4] o_tx.kind == CH_ACK;
  endproperty
  a_owed_send: assert property (p_owed_send)
    else $error("owed ack not sent");
  property p_resend;
    o_resend_all |-> $past(o_outstanding) != 8'h00;
  endproperty
  a_resend: assert property (p_resend)
    else $error("resend with nothing outstanding");
  c_release: cover property (o_release);
  c_timeout: cover property (o_evt.ack_timeout);
  c_reject: cover property (o_evt.frame_reject);
endmodule

bind lafc_port lafc_port_monitor u_mon (.i_core_clk, .i_rst,
  .i_port_state, .i_rx, .i_tx, .o_tx_ready, .o_fwd, .o_chan,
  .o_chan_valid, .o_release, .o_tx, .o_evt, .o_resend_all,
  .o_outstanding, .o_owed);

// File: tb/link_ack_flow_control_tb_top.sv
module link_ack_flow_control_tb_top;
  import lafc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_core_clk = 1'b0;
  logic i_rst = 1'b1;
  lafc_pstate_t i_port_state = PS_READY;
  logic i_ld_enable = 1'b0;
  logic i_reduced_ack_timeout_bit_set = 1'b0;
  logic i_rr_req = 1'b0;
  logic auto = 1'b1;
  logic [7:0] dly = 8'h00;
  lafc_ftype_t ft = FT_NORMAL;
  lafc_tx_t i_tx = '0;
  lafc_rx_t i_rx, o_fwd;
  logic [CHAN_W-1:0] o_chan, chn;
  logic o_chan_valid, o_rr_pair, o_release, o_tx_ready, o_rr_sent;
  logic o_resend_all, o_long_tmo;
  lafc_txo_t o_tx;
  lafc_evt_t o_evt;
  logic [CNT_W-1:0] o_outstanding, o_owed;
  logic [15:0] lfsr = 16'h72e1;
  int n_mismatch = 0, cmp_count = 0, r0, r1, t0, tcyc = 0;
  int n_rel = 0, n_pe = 0, n_rej = 0, n_tmo = 0, n_abt = 0;
  int n_rr = 0, n_fwd = 0, n_ack = 0, n_rrc = 0, n_rrs = 0;

  lafc_port #(.CAPABLE(1'b1)) u_dut (.i_core_clk, .i_rst, .i_port_state,
    .i_ld_enable, .i_reduced_ack_timeout_bit_set, .i_rx, .o_fwd, .o_chan, .o_chan_valid,
    .o_rr_pair, .o_release, .i_tx, .o_tx_ready, .i_rr_req, .o_rr_sent,
    .o_tx, .o_evt, .o_resend_all, .o_long_tmo, .o_outstanding, .o_owed);
  lafc_peer u_peer (.i_core_clk, .i_auto(auto), .i_delay(dly),
    .i_tx(o_tx), .o_rx(i_rx));

  always #12.5 i_core_clk = ~i_core_clk;

  always @(negedge i_core_clk) begin
    tcyc++;
    if (!i_rst) begin
      n_rel += o_release;
      n_pe += o_evt.proto_err;
      n_rej += o_evt.frame_reject;
      n_tmo += o_evt.ack_timeout;
      n_abt += o_evt.abort;
      n_rr += o_rr_pair;
      n_fwd += o_fwd.valid && o_fwd.kind inside {CH_ACK, CH_RR};
      n_ack += o_tx.kind == CH_ACK;
      n_rrc += o_tx.kind == CH_RR;
      n_rrs += o_rr_sent;
    end
  end

  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic acked(input lafc_ftype_t f);
    return f == FT_NORMAL || f == FT_LINK_RESET;
  endfunction
  function automatic lafc_rx_t mk(lafc_chr_t k, logic [7:0] d, logic c,
                                  logic cl);
    return '{1'b1, k, d, c, cl, 1'b1, ft};
  endfunction

  task automatic chk(input string nm, input logic [15:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge i_core_clk);
  endtask
  task automatic drain;
    while (u_peer.q.size() > 0)
      @(negedge i_core_clk);
    cyc(12);
  endtask
  task automatic txc(input lafc_chr_t k, input logic cl);
    @(negedge i_core_clk);
    lfsr = nxt(lfsr);
    i_tx = '{1'b1, k, lfsr[7:0], cl, ft};
    // ready is combinational: look once it has settled
    #1;
    while (!o_tx_ready) begin
      @(negedge i_core_clk);
      #1;
    end
    @(negedge i_core_clk);
    i_tx.valid = 1'b0;
  endtask
  task automatic give_verdict;
    if (n_mismatch == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge i_core_clk);
    n_mismatch++;
    give_verdict();
  end

  initial begin
    cyc(6);
    i_rst = 1'b0;
    cyc(2);
    chk("outstanding", o_outstanding, 0);
    chk("long_tmo", o_long_tmo, 1);
    for (int i = 0; i < 10; i++) begin
      ft = lafc_ftype_t'(i % 5);
      auto = acked(ft);
      lfsr = nxt(lfsr);
      dly = {3'h0, lfsr[4:0]};
      r0 = n_rel;
      txc(CH_DATA, 1'b0);
      txc(CH_FLAG, 1'b1);
      chk("out_inc", o_outstanding, auto);
      cyc(50);
      chk("released", n_rel - r0, auto);
      chk("out_dec", o_outstanding, 0);
    end
    ft = FT_NORMAL;
    auto = 1'b1;
    dly = 8'h28;
    r0 = n_rel;
    txc(CH_FLAG, 1'b1);
    txc(CH_DATA, 1'b0);
    txc(CH_FLAG, 1'b1);
    chk("out_held", o_outstanding, 1);
    cyc(100);
    chk("released2", n_rel - r0, 2);
    r0 = n_pe;
    u_peer.push(mk(CH_ACK, 8'h00, 1'b0, 1'b0));
    u_peer.push(mk(CH_ACK, 8'h00, 1'b0, 1'b0));
    drain();
    chk("pe_pair", n_pe - r0, 1);
    u_peer.push(mk(CH_ACK, 8'h00, 1'b0, 1'b0));
    u_peer.push(mk(CH_DATA, 8'h00, 1'b0, 1'b0));
    drain();
    chk("pe_lone", n_pe - r0, 2);
    for (int i = 0; i < 10; i++) begin
      ft = lafc_ftype_t'(i % 5);
      i_port_state = (i < 5) ? PS_READY : PS_CHECK;
      lfsr = nxt(lfsr);
      chn = (i == 0) ? 14'h007f : (i == 1) ? 14'h3fff :
            (i == 2) ? 14'h0080 : lfsr[13:0];
      r0 = n_ack;
      if (chn < 14'h0080)
        u_peer.push(mk(CH_DATA, {1'b0, chn[6:0]}, 1'b1, 1'b0));
      else begin
        u_peer.push(mk(CH_DATA, {1'b1, chn[13:7]}, 1'b1, 1'b0));
        u_peer.push(mk(CH_DATA, {1'b0, chn[6:0]}, 1'b1, 1'b0));
      end
      u_peer.push(mk(CH_FLAG, 8'h00, 1'b0, 1'b1));
      drain();
      chk("chan", o_chan, chn);
      chk("ack_tx", n_ack - r0, ((i < 5) ? acked(ft) :
          ft == FT_LINK_RESET) ? 2 : 0);
      chk("owed", o_owed, 0);
    end
    i_port_state = PS_READY;
    ft = FT_NORMAL;
    r0 = n_ack;
    repeat (2) begin
      u_peer.push(mk(CH_DATA, 8'h05, 1'b1, 1'b0));
      u_peer.push(mk(CH_FLAG, 8'h00, 1'b0, 1'b1));
    end
    // a frame closed with an error is never acknowledged
    u_peer.push('{1'b1, CH_FLAG, 8'h00, 1'b0, 1'b1, 1'b0, ft});
    drain();
    chk("ack_two", n_ack - r0, 4);
    r0 = n_rej;
    u_peer.push(mk(CH_DATA, 8'h80, 1'b1, 1'b0));
    u_peer.push(mk(CH_DATA, 8'h81, 1'b1, 1'b0));
    u_peer.push(mk(CH_DATA, 8'h85, 1'b1, 1'b0));
    drain();
    chk("reject", n_rej - r0, 2);
    r0 = n_rr;
    repeat (3)
      u_peer.push(mk(CH_RR, 8'h00, 1'b0, 1'b0));
    u_peer.push(mk(CH_DATA, 8'h00, 1'b0, 1'b0));
    drain();
    chk("rr_pair", n_rr - r0, 1);
    chk("rr_fwd", n_fwd, 0);
    i_rr_req = 1'b1;
    fork
      begin
        cyc(1);
        i_rr_req = 1'b0;
      end
      txc(CH_DATA, 1'b0);
    join
    cyc(5);
    chk("rr_tx", n_rrc, 2);
    chk("rr_sent", n_rrs, 1);
    i_reduced_ack_timeout_bit_set = 1'b1;
    cyc(1);
    i_reduced_ack_timeout_bit_set = 1'b0;
    cyc(2);
    chk("short_tmo", o_long_tmo, 0);
    auto = 1'b0;
    r0 = n_tmo;
    r1 = n_abt;
    txc(CH_FLAG, 1'b1);
    t0 = tcyc;
    cyc(990);
    chk("tmo_early", n_tmo - r0, 0);
    txc(CH_DATA, 1'b0);
    txc(CH_FLAG, 1'b1);
    cyc(3);
    chk("tmo", n_tmo - r0, 1);
    chk("tmo_late", tcyc - t0 <= 2000, 1);
    chk("abort", n_abt - r1, 1);
    i_port_state = PS_DISABLED;
    cyc(2);
    chk("out_clr", o_outstanding, 0);
    i_port_state = PS_READY;
    i_ld_enable = 1'b1;
    txc(CH_FLAG, 1'b1);
    txc(CH_FLAG, 1'b1);
    cyc(2);
    chk("out_ld", o_outstanding, 2);
    chk("resend", o_resend_all, 1);
    give_verdict();
  end
endmodule
